// File: logic/pfs_apb_slave.v
/*
 * APB slave front end: address decode, zero-wait answer, read data capture.
 * Assumes a standard APB master with one clock and a synchronous active-high reset.
 */
`default_nettype none
`include "pfs_defs.vh"

module pfs_apb_slave (
    input  wire        i_clk,
    input  wire        i_sys_rst,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_pwdata,
    input  wire [3:0]  i_pstrb,
    input  wire [31:0] i_rd_a,
    input  wire [31:0] i_rd_b,
    input  wire [31:0] i_rd_fault,
    output reg  [31:0] o_prdata,
    output wire        o_pready,
    output wire        o_pslverr,
    output wire        o_wr_a,
    output wire        o_wr_b,
    output wire [31:0] o_wdata,
    output wire [3:0]  o_wstrb
);

    ////////////////////////////////////////////////////////////////////////////
    wire        hit_a;
    wire        hit_b;
    wire        hit_f;
    wire        access;
    wire        bad;
    reg  [31:0] rd_mux;

    assign hit_a  = (i_paddr == `PFS_OFF_CTRL_A);
    assign hit_b  = (i_paddr == `PFS_OFF_CTRL_B);
    assign hit_f  = (i_paddr == `PFS_OFF_FAULT);
    assign access = i_psel & i_penable;
    // The fault word is read-only, so a write to it is answered with an error.
    assign bad    = ~(hit_a | hit_b | hit_f) | (hit_f & i_pwrite);

    assign o_pready  = access;
    assign o_pslverr = access & bad;
    assign o_wr_a    = access & i_pwrite & hit_a;
    assign o_wr_b    = access & i_pwrite & hit_b;
    assign o_wdata   = i_pwdata;
    assign o_wstrb   = i_pstrb;

    always @* begin
        rd_mux = 32'h00000000;
        if (hit_a) begin
            rd_mux = i_rd_a;
        end else if (hit_b) begin
            rd_mux = i_rd_b;
        end else if (hit_f) begin
            rd_mux = i_rd_fault;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data is caught in the setup cycle so it leaves a flip-flop in the
    // access cycle while the answer still costs no wait state.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_prdata <= 32'h00000000;
        end else if (i_psel & ~i_penable & ~i_pwrite) begin
            o_prdata <= rd_mux;
        end
    end

endmodule
`default_nettype wire

// File: logic/pfs_defs.vh
/*
 * Constants shared by the pin function selector: register offsets, field layout,
 * reset values and the selection codes.
 * Assumes it is included by its bare name from every design file of the block.
 */
`ifndef PFS_DEFS_VH
`define PFS_DEFS_VH

// APB byte addresses of the registers.
`define PFS_ADDR_W        12
`define PFS_OFF_CTRL_A    12'h000
`define PFS_OFF_CTRL_B    12'h004
`define PFS_OFF_FAULT     12'h008

// Register layout and reset values.
`define PFS_DATA_W        32
`define PFS_STRB_W        4
`define PFS_FIELD_W       4
`define PFS_FIELDS        8
`define PFS_CTRL_RESET    32'h00000000
`define PFS_FAULT_W       11

// Selection codes; every other code is reserved.
`define PFS_CODE_F0       4'h0
`define PFS_CODE_F1       4'h1
`define PFS_CODE_F2       4'h2
`define PFS_CODE_F4       4'h4
`define PFS_CODE_F8       4'h8

// Pin and slot counts, the first field of B and the pin with no slot 0.
`define PFS_NUM_PINS      11
`define PFS_NUM_SLOTS     5
`define PFS_A_PINS        8
`define PFS_B_FIRST_FIELD 5
`define PFS_PIN_TRISTATE0 9

`endif

// File: logic/pfs_pin_route.v
/*
 * Routes one shared pin to one of five candidate functions by a 4-bit code.
 * Assumes the code comes from a register and the function signals from peripherals.
 */
`default_nettype none
`include "pfs_defs.vh"

module pfs_pin_route #(
    parameter P_HAS_SLOT0 = 1
) (
    input  wire [3:0] i_code,
    input  wire [4:0] i_func_out,
    input  wire [4:0] i_func_oe,
    input  wire       i_pin_in,
    output reg        o_pin_out,
    output reg        o_pin_oe,
    output reg  [4:0] o_func_in,
    output wire       o_reserved
);

    ////////////////////////////////////////////////////////////////////////////
    // A reserved code selects no slot, so the pin is released rather than
    // left driven by a stale function.
    function [4:0] pfs_slot_onehot;
        input [3:0] code;
        input       has0;
        begin
            case (code)
                `PFS_CODE_F0: pfs_slot_onehot = {4'h0, has0};
                `PFS_CODE_F1: pfs_slot_onehot = 5'h02;
                `PFS_CODE_F2: pfs_slot_onehot = 5'h04;
                `PFS_CODE_F4: pfs_slot_onehot = 5'h08;
                `PFS_CODE_F8: pfs_slot_onehot = 5'h10;
                default:      pfs_slot_onehot = 5'h00;
            endcase
        end
    endfunction

    wire [4:0] slot_sel;
    wire       has0;

    assign has0       = (P_HAS_SLOT0 != 0);
    assign slot_sel   = pfs_slot_onehot(i_code, has0);
    assign o_reserved = ~|slot_sel & (i_code != `PFS_CODE_F0);

    ////////////////////////////////////////////////////////////////////////////
    always @* begin
        o_pin_out = |(slot_sel & i_func_out);
        o_pin_oe  = |(slot_sel & i_func_oe);
        o_func_in = slot_sel & {5{i_pin_in}};
    end

endmodule
`default_nettype wire

// File: logic/pfs_top.v
/*
 * Pin function selector for eleven shared pins, programmed through two
 * 32-bit selection registers and observed through a reserved-code status word.
 * Assumes an APB master on the system clock and peripherals that present an
 * output value and output enable per function and accept the pin input back.
 */
`default_nettype none
`include "pfs_defs.vh"


module pfs_top (
    input  wire        i_clk,
    input  wire        i_sys_rst,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_pwdata,
    input  wire [3:0]  i_pstrb,
    output wire [31:0] o_prdata,
    output wire        o_pready,
    output wire        o_pslverr,
    input  wire [54:0] i_func_out,
    input  wire [54:0] i_func_oe,
    output wire [54:0] o_func_in,
    input  wire [10:0] i_pin_in,
    output wire [10:0] o_pin_out,
    output wire [10:0] o_pin_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin order on the vector ports, five slots per pin at index pin*5+slot,
    // slot 0..4 for codes 0, 1h, 2h, 4h, 8h:
    // pin 0  A 3-0   rtu1_input_9, video out 1, display data 1, parallel 9, bank7 9.
    // pin 1  A 7-4   rtu1_input_8, video out 0, display data 0, parallel 8, bank7 8.
    // pin 2  A 11-8  boot 7, video out 15, display data 15, parallel 7, bank7 7.
    // pin 3  A 15-12 boot 6, video out 14, display data 14, parallel 6, bank7 6.
    // pin 4  A 19-16 boot 5, video_out_bit_13, display_data_bit_13, parallel_data_bit_5,
    //                general_bank7_bit5.
    // pin 5  A 23-20 boot 4, video out 12, display data 12, parallel 4, bank7 4.
    // pin 6  A 27-24 boot 3, video out 11, display data 11, parallel 3, bank7 3.
    // pin 7  A 31-28 boot 2, video out 10, display data 10, parallel 2, bank7 2.
    // pin 8  B 23-20 rtu1_input_24, rtu0_output_22, rtu1_output_8, parallel_ch0_wait,
    //                general_bank8_bit12.
    // pin 9  B 27-24 none, card_data_7, display_pixel_clock, rtu1_output_7,
    //                general_bank8_bit11.
    // pin 10 B 31-28 rtu1 in 7, card_data_6, display_master_clock, rtu1_output_6,
    //                general_bank8_bit10.

    reg  [31:0] pin_select_ctrl_a_reg;
    reg  [31:0] pin_select_ctrl_a_next;
    reg  [31:0] pin_select_ctrl_b_reg;
    reg  [31:0] pin_select_ctrl_b_next;
    wire        wr_a;
    wire        wr_b;
    wire [31:0] wdata;
    wire [3:0]  wstrb;
    wire [10:0] pin_reserved;
    wire [31:0] fault_word;
    integer     lane;

    wire [3:0]  sel_a_field_3_0;
    wire [3:0]  sel_a_field_7_4;
    wire [3:0]  sel_a_field_11_8;
    wire [3:0]  sel_a_field_15_12;
    wire [3:0]  sel_a_field_19_16;
    wire [3:0]  sel_b_field_23_20;
    wire [3:0]  sel_b_field_27_24;
    wire [3:0]  sel_b_field_31_28;

    assign sel_a_field_3_0   = pin_select_ctrl_a_reg[3:0];
    assign sel_a_field_7_4   = pin_select_ctrl_a_reg[7:4];
    assign sel_a_field_11_8  = pin_select_ctrl_a_reg[11:8];
    assign sel_a_field_15_12 = pin_select_ctrl_a_reg[15:12];
    assign sel_a_field_19_16 = pin_select_ctrl_a_reg[19:16];
    assign sel_b_field_23_20 = pin_select_ctrl_b_reg[23:20];
    assign sel_b_field_27_24 = pin_select_ctrl_b_reg[27:24];
    assign sel_b_field_31_28 = pin_select_ctrl_b_reg[31:28];

    ////////////////////////////////////////////////////////////////////////////
    pfs_apb_slave u_apb (
        .i_clk      (i_clk),
        .i_sys_rst  (i_sys_rst),
        .i_psel     (i_psel),
        .i_penable  (i_penable),
        .i_pwrite   (i_pwrite),
        .i_paddr    (i_paddr),
        .i_pwdata   (i_pwdata),
        .i_pstrb    (i_pstrb),
        .i_rd_a     (pin_select_ctrl_a_reg),
        .i_rd_b     (pin_select_ctrl_b_reg),
        .i_rd_fault (fault_word),
        .o_prdata   (o_prdata),
        .o_pready   (o_pready),
        .o_pslverr  (o_pslverr),
        .o_wr_a     (wr_a),
        .o_wr_b     (wr_b),
        .o_wdata    (wdata),
        .o_wstrb    (wstrb)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Byte strobes let software retarget a pair of pins without a
    // read-modify-write that could glitch the others.
    always @* begin
        pin_select_ctrl_a_next = pin_select_ctrl_a_reg;
        pin_select_ctrl_b_next = pin_select_ctrl_b_reg;
        for (lane = 0; lane < `PFS_STRB_W; lane = lane + 1) begin
            if (wr_a && wstrb[lane]) begin
                pin_select_ctrl_a_next[lane*8 +: 8] = wdata[lane*8 +: 8];
            end
            if (wr_b && wstrb[lane]) begin
                pin_select_ctrl_b_next[lane*8 +: 8] = wdata[lane*8 +: 8];
            end
        end
    end

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            pin_select_ctrl_a_reg <= `PFS_CTRL_RESET;
            pin_select_ctrl_b_reg <= `PFS_CTRL_RESET;
        end else begin
            pin_select_ctrl_a_reg <= pin_select_ctrl_a_next;
            pin_select_ctrl_b_reg <= pin_select_ctrl_b_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reserved codes are stored as written, but the pin is released and the
    // status word flags it; this cannot stop a careless write.
    assign fault_word = {21'h000000, pin_reserved};

    genvar p;
    generate
        for (p = 0; p < `PFS_NUM_PINS; p = p + 1) begin : g_pin
            localparam integer FLD = (p < `PFS_A_PINS) ? p : (p - `PFS_A_PINS + `PFS_B_FIRST_FIELD);
            wire [3:0] code;
            if (p < `PFS_A_PINS) begin : g_a
                assign code = pin_select_ctrl_a_reg[FLD*4 +: 4];
            end else begin : g_b
                assign code = pin_select_ctrl_b_reg[FLD*4 +: 4];
            end
            pfs_pin_route #(
                .P_HAS_SLOT0 ((p == `PFS_PIN_TRISTATE0) ? 0 : 1)
            ) u_route (
                .i_code     (code),
                .i_func_out (i_func_out[p*5 +: 5]),
                .i_func_oe  (i_func_oe[p*5 +: 5]),
                .i_pin_in   (i_pin_in[p]),
                .o_pin_out  (o_pin_out[p]),
                .o_pin_oe   (o_pin_oe[p]),
                .o_func_in  (o_func_in[p*5 +: 5]),
                .o_reserved (pin_reserved[p])
            );
        end
    endgenerate

endmodule
`default_nettype wire

// File: logic/README_unused.v
`default_nettype none
`default_nettype wire

// File: verif/pfs_assertions.sv
/* Checker for pfs_top: APB answer, register read-back and pin routing.
   Assumes it is bound to pfs_top and sees only that module's ports. */
`default_nettype none
module pfs_checker (
    input wire logic        i_clk,
    input wire logic        i_sys_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0]  i_pstrb,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic [54:0] i_func_out,
    input wire logic [54:0] i_func_oe,
    input wire logic [54:0] o_func_in,
    input wire logic [10:0] i_pin_in,
    input wire logic [10:0] o_pin_out,
    input wire logic [10:0] o_pin_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] sh_a_reg;
    logic [31:0] sh_b_reg;
    logic [2:0]  slot [11];
    // Shadow copies let routing be judged without seeing the design's registers.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            sh_a_reg <= 32'h0;
            sh_b_reg <= 32'h0;
        end else if (i_psel && i_penable && i_pwrite) begin
            for (int k = 0; k < 4; k++) begin
                if (i_pstrb[k] && i_paddr == 12'h000) sh_a_reg[8*k+:8] <= i_pwdata[8*k+:8];
                if (i_pstrb[k] && i_paddr == 12'h004) sh_b_reg[8*k+:8] <= i_pwdata[8*k+:8];
            end
        end
    end
    function automatic logic [2:0] to_slot(input logic [3:0] c);
        return (c == 4'h0) ? 3'h0 : (c == 4'h1) ? 3'h1 : (c == 4'h2) ? 3'h2 : (c == 4'h4) ? 3'h3 :
               (c == 4'h8) ? 3'h4 : 3'h7;
    endfunction
    always_comb begin
        for (int p = 0; p < 8; p++) slot[p] = to_slot(sh_a_reg[4*p+:4]);
        slot[8] = to_slot(sh_b_reg[23:20]);
        slot[9] = to_slot(sh_b_reg[27:24]);
        slot[10] = to_slot(sh_b_reg[31:28]);
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_rd_setup;
        i_psel && !i_penable && !i_pwrite && (i_paddr == 12'h000 || i_paddr == 12'h004);
    endsequence
    sequence s_access;
        i_psel && i_penable;
    endsequence
    property p_read;
        s_rd_setup ##1 s_access |-> o_prdata == ((i_paddr == 12'h000) ? sh_a_reg : sh_b_reg);
    endproperty
    property p_ready;
        o_pready == (i_psel && i_penable);
    endproperty
    property p_reset;
        $fell(i_sys_rst) |-> o_prdata == 32'h0 && !o_pin_oe[9] && !o_pin_out[9];
    endproperty
    property p_float;
        slot[9] == 3'h0 |-> !o_pin_oe[9] && !o_pin_out[9];
    endproperty
    property p_route(int p);
        slot[p] != 3'h7 && !(p == 9 && slot[p] == 3'h0) |->
            o_pin_out[p] == i_func_out[p*5+slot[p]] && o_pin_oe[p] == i_func_oe[p*5+slot[p]];
    endproperty
    property p_reserved(int p);
        slot[p] == 3'h7 |-> !o_pin_oe[p] && !o_pin_out[p] && o_func_in[p*5+:5] == 5'h00;
    endproperty
    property p_input(int p);
        slot[p] != 3'h7 && p != 9 |-> o_func_in[p*5+:5] == (5'(i_pin_in[p]) << slot[p]);
    endproperty
    a_read: assert property (p_read) else $error("read data differs from stored selection");
    a_ready: assert property (p_ready) else $error("ready not tied to access phase");
    a_reset: assert property (p_reset) else $error("state not cleared by reset");
    a_float: assert property (p_float) else $error("floating pin is driven");
    for (genvar p = 0; p < 11; p++) begin : g_pin
        a_route: assert property (p_route(p)) else $error("pin output not from chosen function");
        a_reserved: assert property (p_reserved(p)) else $error("reserved code drives pin");
        a_input: assert property (p_input(p)) else $error("pin input not routed to chosen function");
    end
    for (genvar p = 0; p < 5; p++) begin : g_alow
        a_route_a_low: assert property (p_route(p)) else $error("low field route wrong");
    end
    for (genvar p = 5; p < 8; p++) begin : g_ahigh
        a_route_a_high: assert property (p_route(p)) else $error("high field route wrong");
    end
    a_route_b_mid: assert property (p_route(8)) else $error("field 23-20 route wrong");
    a_route_b_top: assert property (p_route(10)) else $error("field 31-28 route wrong");
endmodule
bind pfs_top pfs_checker u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_func_out(i_func_out), .i_func_oe(i_func_oe),
    .o_func_in(o_func_in), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe));
`default_nettype wire

// File: verif/tb_pin_function_select_17_18.sv
/* Self-checking bench for pfs_top: APB tasks, code tables and pin expectations.
   Assumes zero-wait APB answers and combinational pin routing. */
`default_nettype none
module tb_pin_function_select_17_18;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_clk = 1'b0, i_sys_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, rd, sh_a = 32'h0, sh_b = 32'h0;
    logic [3:0]  i_pstrb = 4'h0, good [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
    logic [3:0]  rsv [11] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
    logic [54:0] i_func_out = 55'h2A_F0C3_5A96_1E87, i_func_oe = 55'h15_0F3C_A569_E178;
    logic [10:0] i_pin_in = 11'h5A3, fm = 11'h000;
    logic        err;
    wire  [31:0] o_prdata;
    wire         o_pready, o_pslverr;
    wire  [54:0] o_func_in;
    wire  [10:0] o_pin_out, o_pin_oe;
    int          num_errors = 0, tests_run = 0;
    pfs_top uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_func_out(i_func_out), .i_func_oe(i_func_oe), .o_func_in(o_func_in),
        .i_pin_in(i_pin_in), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe));
    initial begin
        forever #2.5 i_clk = ~i_clk;
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // Enter right after a rising edge; the request is held until pready is seen.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        i_pstrb <= s;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            if (wr && s[k] && a == 12'h000) sh_a[8*k+:8] = d[8*k+:8];
            if (wr && s[k] && a == 12'h004) sh_b[8*k+:8] = d[8*k+:8];
        end
        // One idle edge, so a following call never re-raises psel in the same time step.
        @(posedge i_clk);
    endtask
    task automatic check_pins();
        logic [3:0]  c;
        int          s;
        logic [10:0] eo, ee;
        logic [54:0] ei;
        @(negedge i_clk);
        for (int p = 0; p < 11; p++) begin
            c = (p < 8) ? sh_a[4*p+:4] : (p == 8) ? sh_b[23:20] : (p == 9) ? sh_b[27:24] : sh_b[31:28];
            s = (c == 4'h0) ? 0 : (c == 4'h1) ? 1 : (c == 4'h2) ? 2 : (c == 4'h4) ? 3 : (c == 4'h8) ? 4 : -1;
            if (p == 9 && c == 4'h0) s = -1;
            fm[p] = (s < 0) && !(p == 9 && c == 4'h0);
            eo[p] = (s < 0) ? 1'b0 : i_func_out[p*5+s];
            ee[p] = (s < 0) ? 1'b0 : i_func_oe[p*5+s];
            ei[p*5+:5] = (s < 0) ? 5'h00 : (5'(i_pin_in[p]) << s);
        end
        check(64'(o_pin_out), 64'(eo), "pin out");
        check(64'(o_pin_oe), 64'(ee), "pin enable");
        check(64'(o_func_in), 64'(ei), "function in");
        @(posedge i_clk);
    endtask
    task automatic round(input logic [31:0] w, input logic [3:0] s);
        apb(1'b1, 12'h000, w, 4'hF);
        apb(1'b1, 12'h004, w, s);
        check_pins();
        apb(1'b0, 12'h000, 32'h0, 4'h0);
        check(64'(rd), 64'(sh_a), "read a");
        check(64'(err), 64'h0, "read a error");
        apb(1'b0, 12'h004, 32'h0, 4'h0);
        check(64'(rd), 64'(sh_b), "read b");
        apb(1'b0, 12'h008, 32'h0, 4'h0);
        check(64'(rd), 64'(fm), "fault word");
        i_pin_in <= ~i_pin_in;
        i_func_oe <= ~i_func_oe;
        i_func_out <= {i_func_out[53:0], i_func_out[54]};
    endtask
    task automatic results();
        $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        apb(1'b0, 12'h004, 32'h0, 4'h0);
        check(64'(rd), 64'h0, "reset b");
        check_pins();
        $display("test reset done");
        foreach (good[i]) round({8{good[i]}}, 4'hF);
        $display("test codes done");
        foreach (rsv[i]) round({8{rsv[i]}}, 4'hF);
        $display("test reserved done");
        round(32'h8421_3842, 4'h5);
        round(32'h4812_0184, 4'hA);
        $display("test strobes done");
        apb(1'b0, 12'h00C, 32'h0, 4'h0);
        check(64'({err, rd}), 64'({1'b1, 32'h0}), "unmapped read");
        apb(1'b1, 12'h002, 32'hFFFF_FFFF, 4'hF);
        check(64'(err), 64'h1, "misaligned write");
        check_pins();
        $display("test refusals done");
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        sh_a = 32'h0;
        sh_b = 32'h0;
        @(posedge i_clk);
        apb(1'b0, 12'h000, 32'h0, 4'h0);
        check(64'(rd), 64'h0, "second reset a");
        apb(1'b0, 12'h004, 32'h0, 4'h0);
        check(64'(rd), 64'h0, "second reset b");
        round(32'h0, 4'h0);
        $display("test second reset done");
        results();
    end
    initial begin
        repeat (5000) @(posedge i_clk);
        num_errors++;
        results();
    end
endmodule
`default_nettype wire
